// [logic/pcc_pkg.sv]
// constants shared by the port pin control block
package pcc_pkg;
   // ----------------------------------------------------------------
   // port indices and write targets
   // ----------------------------------------------------------------
   localparam logic [1:0] PORT_P2      = 2'h0;
   localparam logic [1:0] PORT_P3      = 2'h1;
   localparam logic [1:0] PORT_P4      = 2'h2;
   localparam logic [1:0] PORT_P12     = 2'h3;
   localparam logic [1:0] TGT_LATCH    = 2'h0; // output latch / pin view
   localparam logic [1:0] TGT_MODE     = 2'h1; // 1 = output mode
   localparam logic [1:0] TGT_PULLUP   = 2'h2;
   localparam logic [1:0] TGT_ANALOG   = 2'h3; // port 2 only
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int         ANALOG_BITS      = 4;
   localparam int         RESET_PIN_BIT    = 4;  // port 3
   localparam int         IRQ_A_BIT        = 0;  // port 3
   localparam int         IRQ_B_BIT        = 1;  // port 3
   localparam int         IRQ_C_BIT        = 3;  // port 4
   localparam int         OSC_IN_BIT       = 1;  // port 12
   localparam int         OSC_OUT_BIT      = 2;  // port 12
   localparam int         OPT_RST_PORT_BIT = 0;  // option byte field
   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] PORT_RESET_VAL   = 8'h00;
   localparam logic [3:0] ANALOG_RESET_VAL = 4'h0;
   localparam logic [2:0] OPT_READ_CYCLES  = 3'h4;
   // reset sequencer states, gray along hold -> read -> run
   typedef enum logic [1:0] {
      PCC_HOLD = 2'b00,
      PCC_READ = 2'b01,
      PCC_RUN  = 2'b11
   } pcc_state_e;
endpackage

// [logic/pcc_sync.sv]
// two-flop synchroniser for a vector of pin inputs
module pcc_sync #(
   parameter int WIDTH = 32
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   // ----------------------------------------------------------------
   // per-bit double flop
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic stage1_reg;
         logic stage2_reg;
         // first stage is read only by the second
         always_ff @(posedge clock) begin
            if (!reset_n) begin
               stage1_reg <= 1'b0;
               stage2_reg <= 1'b0;
            end else begin
               stage1_reg <= async_in[i];
               stage2_reg <= stage1_reg;
            end
         end
         assign sync_out[i] = stage2_reg;
      end
   endgenerate
endmodule // pcc_sync

// [logic/pcc_port.sv]
// port pin control: shared oscillator, reset, irq and analog pins
// Notes on behaviour
// - while the device is in reset both oscillator pins are pulled down.
// - the option byte makes the reset pin either reset input or input port.
// - the option byte is read after release and a low reset pin holds reset.
// - toggling an irq-shared pin in output mode sets its request flag.
// - a set analog-select bit turns its port 2 pin into an A/D input.
// - a single-bit write reads and rewrites the whole 8-bit port.
module pcc_port
   import pcc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic [7:0] option_byte,
   input  wire logic [7:0] p2_in,
   input  wire logic [7:0] p3_in,
   input  wire logic [7:0] p4_in,
   input  wire logic [7:0] p12_in,
   input  wire logic       wr_strobe,
   input  wire logic       bit_strobe,
   input  wire logic [1:0] wr_port,
   input  wire logic [1:0] wr_target,
   input  wire logic [7:0] wr_data,
   input  wire logic [2:0] bit_index,
   input  wire logic       bit_value,
   input  wire logic [1:0] rd_port,
   input  wire logic [1:0] rd_target,
   input  wire logic [2:0] irq_flag_clr,
   input  wire logic [2:0] irq_mask,
   output logic      [7:0] rd_data,
   output logic      [7:0] p2_out,
   output logic      [7:0] p2_oe,
   output logic      [7:0] p2_pullup,
   output logic      [7:0] p3_out,
   output logic      [7:0] p3_oe,
   output logic      [7:0] p3_pullup,
   output logic      [7:0] p4_out,
   output logic      [7:0] p4_oe,
   output logic      [7:0] p4_pullup,
   output logic      [7:0] p12_out,
   output logic      [7:0] p12_oe,
   output logic      [7:0] p12_pullup,
   output logic      [3:0] analog_en,
   output logic      [1:0] osc_pulldown,
   output logic            core_reset_n,
   output logic            reset_pin_is_port,
   output logic      [2:0] irq_flag,
   output logic      [2:0] irq_req
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [31:0] pin_sync;
   pcc_sync #(
      .WIDTH    (32)
   ) u_sync (
      .clock    (clock),
      .reset_n  (reset_n),
      .async_in ({p12_in, p4_in, p3_in, p2_in}),
      .sync_out (pin_sync)
   );
   logic rst_pin_level;
   assign rst_pin_level = pin_sync[8 + RESET_PIN_BIT];
   // ----------------------------------------------------------------
   // reset sequencer and option byte
   // ----------------------------------------------------------------
   pcc_state_e state_reg;
   pcc_state_e state_next;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic       port_mode_reg;
   logic       port_mode_next;
   logic       run;
   // option read starts after release; low pin restarts the wait
   always_comb begin
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      port_mode_next = port_mode_reg;
      case (state_reg)
         PCC_HOLD: begin
            state_next = PCC_READ;
            cnt_next   = 3'h0;
         end
         PCC_READ: begin
            if (!rst_pin_level) begin
               cnt_next = 3'h0;
            end else if (cnt_reg == OPT_READ_CYCLES - 3'h1) begin
               port_mode_next = option_byte[OPT_RST_PORT_BIT];
               state_next     = PCC_RUN;
            end else begin
               cnt_next = cnt_reg + 3'h1;
            end
         end
         PCC_RUN: begin
            if (!port_mode_reg && !rst_pin_level) begin
               state_next = PCC_HOLD;
            end
         end
         default: begin
            state_next = PCC_HOLD;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_reg     <= PCC_HOLD;
         cnt_reg       <= 3'h0;
         port_mode_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         port_mode_reg <= port_mode_next;
      end
   end
   assign run = (state_reg == PCC_RUN);
   // ----------------------------------------------------------------
   // port state and cpu writes
   // ----------------------------------------------------------------
   logic [7:0] latch_reg [0:3];
   logic [7:0] latch_next [0:3];
   logic [7:0] dir_reg [0:3];
   logic [7:0] dir_next [0:3];
   logic [7:0] pu_reg [0:3];
   logic [7:0] pu_next [0:3];
   logic [3:0] ana_reg;
   logic [3:0] ana_next;
   logic [7:0] pin_view [0:3];
   logic [7:0] port_mask [0:3];
   logic [7:0] rmw_val;
   // visible pin levels; analog and reset-function pins read zero
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         port_mask[p] = 8'hFF;
         for (int b = 0; b < 8; b++) begin
            pin_view[p][b] = dir_reg[p][b] ? latch_reg[p][b]
                                           : pin_sync[8 * p + b];
         end
      end
      port_mask[0][ANALOG_BITS-1:0] = ~ana_reg;
      port_mask[1][RESET_PIN_BIT] = port_mode_reg;
      for (int p = 0; p < 4; p++) begin
         pin_view[p] = pin_view[p] & port_mask[p];
      end
   end

   // byte write or bit read-modify-write of a whole port
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         latch_next[p] = latch_reg[p];
         dir_next[p]   = dir_reg[p];
         pu_next[p]    = pu_reg[p];
      end
      ana_next = ana_reg;
      case (wr_target)
         TGT_LATCH:  rmw_val = pin_view[wr_port];
         TGT_MODE:   rmw_val = dir_reg[wr_port];
         TGT_PULLUP: rmw_val = pu_reg[wr_port];
         default:    rmw_val = {4'h0, ana_reg};
      endcase
      if (bit_strobe) begin
         rmw_val[bit_index] = bit_value;
      end else begin
         rmw_val = wr_data;
      end
      if (!run) begin
         for (int p = 0; p < 4; p++) begin
            latch_next[p] = PORT_RESET_VAL;
            dir_next[p]   = PORT_RESET_VAL;
            pu_next[p]    = PORT_RESET_VAL;
         end
         ana_next = ANALOG_RESET_VAL;
      end else if (wr_strobe || bit_strobe) begin
         case (wr_target)
            TGT_LATCH:  latch_next[wr_port] = rmw_val;
            TGT_MODE:   dir_next[wr_port]   = rmw_val;
            TGT_PULLUP: pu_next[wr_port]    = rmw_val;
            default: begin
               if (wr_port == PORT_P2) begin
                  ana_next = rmw_val[ANALOG_BITS-1:0];
               end
            end
         endcase
      end
   end

   // port registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int p = 0; p < 4; p++) begin
            latch_reg[p] <= PORT_RESET_VAL;
            dir_reg[p]   <= PORT_RESET_VAL;
            pu_reg[p]    <= PORT_RESET_VAL;
         end
         ana_reg <= ANALOG_RESET_VAL;
      end else begin
         for (int p = 0; p < 4; p++) begin
            latch_reg[p] <= latch_next[p];
            dir_reg[p]   <= dir_next[p];
            pu_reg[p]    <= pu_next[p];
         end
         ana_reg <= ana_next;
      end
   end

   // ----------------------------------------------------------------
   // interrupt-shared pins
   // ----------------------------------------------------------------
   logic [2:0] irq_level;
   logic [2:0] irq_prev_reg;
   logic [2:0] irq_flag_reg;
   logic [2:0] irq_flag_next;
   logic [2:0] irq_req_next;
   // level seen by the detector: driven latch in output mode
   assign irq_level = {pin_view[2][IRQ_C_BIT],
                       pin_view[1][IRQ_B_BIT],
                       pin_view[1][IRQ_A_BIT]};
   // any level change sets the flag; set wins over clear
   always_comb begin
      irq_flag_next = (irq_flag_reg & ~irq_flag_clr)
                    | (irq_level ^ irq_prev_reg);
      if (!run) begin
         irq_flag_next = 3'h0;
      end
      irq_req_next = irq_flag_next & ~irq_mask;
   end

   // irq registers; previous level tracks even outside run
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         irq_prev_reg <= 3'h0;
         irq_flag_reg <= 3'h0;
         irq_req      <= 3'h0;
      end else begin
         irq_prev_reg <= irq_level;
         irq_flag_reg <= irq_flag_next;
         irq_req      <= irq_req_next;
      end
   end
   assign irq_flag = irq_flag_reg;
   // ----------------------------------------------------------------
   // registered pin drive and read data
   // ----------------------------------------------------------------
   logic [7:0] oe_next [0:3];
   logic [7:0] pull_next [0:3];
   logic [7:0] rd_next;
   // drive enables drop for analog, reset-shared and held pins
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         oe_next[p]   = run ? (dir_reg[p] & port_mask[p]) : 8'h00;
         pull_next[p] = run ? (pu_reg[p] & port_mask[p]) : 8'h00;
      end
      oe_next[1][RESET_PIN_BIT] = 1'b0;
      case (rd_target)
         TGT_LATCH:  rd_next = pin_view[rd_port];
         TGT_MODE:   rd_next = dir_reg[rd_port];
         TGT_PULLUP: rd_next = pu_reg[rd_port];
         default:    rd_next = (rd_port == PORT_P2) ? {4'h0, ana_reg}
                                                    : 8'h00;
      endcase
   end

   // output flops
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         {p2_out, p3_out, p4_out, p12_out} <= 32'h0;
         {p2_oe, p3_oe, p4_oe, p12_oe}     <= 32'h0;
         {p2_pullup, p3_pullup}            <= 16'h0;
         {p4_pullup, p12_pullup}           <= 16'h0;
         rd_data           <= 8'h00;
         analog_en         <= 4'h0;
         osc_pulldown      <= 2'h3;
         core_reset_n      <= 1'b0;
         reset_pin_is_port <= 1'b0;
      end else begin
         p2_out            <= latch_reg[0];
         p3_out            <= latch_reg[1];
         p4_out            <= latch_reg[2];
         p12_out           <= latch_reg[3];
         p2_oe             <= oe_next[0];
         p3_oe             <= oe_next[1];
         p4_oe             <= oe_next[2];
         p12_oe            <= oe_next[3];
         p2_pullup         <= pull_next[0];
         p3_pullup         <= pull_next[1];
         p4_pullup         <= pull_next[2];
         p12_pullup        <= pull_next[3];
         rd_data           <= rd_next;
         analog_en         <= ana_reg;
         osc_pulldown      <= {2{~run}};
         core_reset_n      <= run;
         reset_pin_is_port <= port_mode_reg;
      end
   end
endmodule // pcc_port

// [verification/pcc_asserts.sv]
// checker holding the port-level properties of the port pin control
module pcc_asserts
   import pcc_pkg::*;
(
   input wire logic       clock,
   input wire logic       reset_n,
   input wire logic [7:0] p3_in,
   input wire logic [1:0] rd_port,
   input wire logic [1:0] rd_target,
   input wire logic [2:0] irq_mask,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] p2_pullup,
   input wire logic [7:0] p3_out,
   input wire logic [7:0] p3_oe,
   input wire logic [7:0] p3_pullup,
   input wire logic [7:0] p4_out,
   input wire logic [7:0] p4_oe,
   input wire logic [3:0] analog_en,
   input wire logic [1:0] osc_pulldown,
   input wire logic       core_reset_n,
   input wire logic       reset_pin_is_port,
   input wire logic [2:0] irq_flag,
   input wire logic [2:0] irq_req
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // properties
   // ----
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_pd_on; !core_reset_n |-> osc_pulldown == 2'h3; endproperty
   a_pd_on: assert property (p_pd_on) else $error("pull-down off");
   property p_pd_off; core_reset_n |-> osc_pulldown == 2'h0; endproperty
   a_pd_off: assert property (p_pd_off) else $error("pull-down on");
   property p_pin_rst;
      core_reset_n && !reset_pin_is_port && $fell(p3_in[RESET_PIN_BIT])
      |-> ##[1:6] !core_reset_n;
   endproperty
   a_pin_rst: assert property (p_pin_rst) else $error("no pin reset");
   property p_port; core_reset_n && reset_pin_is_port |=> core_reset_n;
   endproperty
   a_port: assert property (p_port) else $error("port pin reset");
   property p_rst_pin_off;
      !p3_oe[RESET_PIN_BIT]
      && (reset_pin_is_port || !p3_pullup[RESET_PIN_BIT]);
   endproperty
   a_rst_pin_off: assert property (p_rst_pin_off) else $error("pin on");
   property p_hold; (!core_reset_n && !p3_in[4])[*5] |=> !core_reset_n;
   endproperty
   a_hold: assert property (p_hold) else $error("left reset");
   property p_irq_a;
      $changed(p3_out[0]) && p3_oe[0] && $past(p3_oe[0])
      |-> ##[0:1] irq_flag[0];
   endproperty
   a_irq_a: assert property (p_irq_a) else $error("no flag a");
   property p_irq_c;
      $changed(p4_out[3]) && p4_oe[3] && $past(p4_oe[3])
      |-> ##[0:1] irq_flag[2];
   endproperty
   a_irq_c: assert property (p_irq_c) else $error("no flag c");
   property p_mask; (irq_mask & $past(irq_mask) & irq_req) == 3'h0; endproperty
   a_mask: assert property (p_mask) else $error("masked request");
   property p_an_pull; (analog_en & $past(analog_en) & p2_pullup[3:0]) == 4'h0;
   endproperty
   a_an_pull: assert property (p_an_pull) else $error("a/d pull-up");
   property p_an_rd;
      $past(rd_port == PORT_P2 && rd_target == TGT_LATCH)
      |-> (rd_data[3:0] & analog_en & $past(analog_en)) == 4'h0;
   endproperty
   a_an_rd: assert property (p_an_rd) else $error("a/d pin read");
   c_run: cover property ($rose(core_reset_n));
   c_irq: cover property ($rose(irq_flag[0]));
   c_an: cover property (analog_en == 4'hF);
endmodule // pcc_asserts

// [verification/pcc_board.sv]
// board model driving the pin levels seen by one port
module pcc_board (
   input  wire logic [7:0] oe,
   input  wire logic [7:0] out,
   input  wire logic [7:0] level,
   output logic      [7:0] pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // a driven pin shows the latch, an undriven one the board level
   always_comb begin
      pin = (oe & out) | (~oe & level);
   end
endmodule // pcc_board

// [verification/pcc_port_tb.sv]
// self-checking testbench for the port pin control block
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module pcc_port_tb
   import pcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // signals and instances
   // ----
   logic       clock = 1'b0, reset_n = 1'b0;
   logic [7:0] option_byte = 8'h00, wr_data = 8'h00;
   logic [7:0] lv2 = 8'h00, lv3 = 8'hEF, lv4 = 8'h00, lv12 = 8'h00;
   logic       wr_strobe = 1'b0, bit_strobe = 1'b0, bit_value = 1'b0;
   logic [1:0] wr_port = 2'h0, wr_target = 2'h0;
   logic [1:0] rd_port = 2'h0, rd_target = 2'h0;
   logic [2:0] bit_index = 3'h0, irq_flag_clr = 3'h0, irq_mask = 3'h7;
   wire  [7:0] rd_data, p2_in, p3_in, p4_in, p12_in;
   wire  [7:0] p2_out, p2_oe, p2_pullup, p3_out, p3_oe, p3_pullup;
   wire  [7:0] p4_out, p4_oe, p4_pullup, p12_out, p12_oe, p12_pullup;
   wire  [3:0] analog_en;
   wire  [1:0] osc_pulldown;
   wire  [2:0] irq_flag, irq_req;
   wire        core_reset_n, reset_pin_is_port;
   int         errors = 0, tests_run = 0;
   always #50 clock = ~clock;
   pcc_board u_b2 (.oe(p2_oe), .out(p2_out), .level(lv2), .pin(p2_in));
   pcc_board u_b3 (.oe(p3_oe), .out(p3_out), .level(lv3), .pin(p3_in));
   pcc_board u_b4 (.oe(p4_oe), .out(p4_out), .level(lv4), .pin(p4_in));
   pcc_board u_b12 (.oe(p12_oe), .out(p12_out), .level(lv12), .pin(p12_in));
   pcc_port u_dut (.clock, .reset_n, .option_byte, .p2_in, .p3_in, .p4_in,
      .p12_in, .wr_strobe, .bit_strobe, .wr_port, .wr_target, .wr_data,
      .bit_index, .bit_value, .rd_port, .rd_target, .irq_flag_clr, .irq_mask,
      .rd_data, .p2_out, .p2_oe, .p2_pullup, .p3_out, .p3_oe, .p3_pullup,
      .p4_out, .p4_oe, .p4_pullup, .p12_out, .p12_oe, .p12_pullup, .analog_en,
      .osc_pulldown, .core_reset_n, .reset_pin_is_port, .irq_flag, .irq_req);
   // ----
   // tasks and scenarios
   // ----
   // step off the edge after n edges
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // byte write, or bit write with d = {value, index}
   task automatic wr(input logic b, input logic [1:0] p, t,
                     input logic [7:0] d);
      @(posedge clock);
      wr_strobe <= !b;
      bit_strobe <= b;
      wr_port <= p;
      wr_target <= t;
      wr_data <= d;
      bit_index <= d[2:0];
      bit_value <= d[3];
      @(posedge clock);
      wr_strobe <= 1'b0;
      bit_strobe <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] p, t, output logic [7:0] d);
      @(posedge clock);
      rd_port <= p;
      rd_target <= t;
      tick(2);
      d = rd_data;
   endtask
   task automatic clr();
      @(posedge clock);
      irq_flag_clr <= 3'h7;
      @(posedge clock);
      irq_flag_clr <= 3'h0;
      tick(1);
   endtask
   task automatic do_reset(input logic [7:0] opt);
      @(posedge clock);
      reset_n <= 1'b0;
      option_byte <= opt;
      tick(1);
      `CHK(osc_pulldown, 2'h3)
      @(posedge clock);
      reset_n <= 1'b1;
   endtask
   task automatic wait_run();
      for (int i = 0; i < 30 && core_reset_n !== 1'b1; i++) tick(1);
      `CHK(core_reset_n, 1'b1)
      `CHK(osc_pulldown, 2'h0)
   endtask
   task automatic s_hold();
      do_reset(8'h00);
      tick(20);
      `CHK(core_reset_n, 1'b0)
      @(posedge clock);
      lv3 <= 8'hFF;
      wait_run();
   endtask
   task automatic s_rst_pin();
      logic [7:0] d;
      @(posedge clock);
      lv3 <= 8'hEF;
      tick(8);
      `CHK(core_reset_n, 1'b0)
      @(posedge clock);
      lv3 <= 8'hFF;
      wait_run();
      do_reset(8'h01);
      wait_run();
      `CHK(reset_pin_is_port, 1'b1)
      @(posedge clock);
      lv3 <= 8'hEF;
      tick(10);
      `CHK(core_reset_n, 1'b1)
      rd(PORT_P3, TGT_LATCH, d);
      `CHK(d, 8'hEF)
      @(posedge clock);
      lv3 <= 8'hFF;
   endtask
   task automatic s_irq();
      logic [1:0] p [3] = '{PORT_P3, PORT_P3, PORT_P4};
      int         b [3] = '{IRQ_A_BIT, IRQ_B_BIT, IRQ_C_BIT};
      for (int k = 0; k < 3; k++) begin
         wr(0, p[k], TGT_MODE, 8'h01 << b[k]);
         tick(3);
         clr();
         `CHK(irq_flag[k], 1'b0)
         wr(0, p[k], TGT_LATCH, 8'h01 << b[k]);
         tick(3);
         `CHK(irq_flag[k], 1'b1)
         `CHK(irq_req[k], 1'b0)
         @(posedge clock);
         irq_mask <= 3'h0;
         tick(2);
         `CHK(irq_req[k], 1'b1)
         @(posedge clock);
         irq_mask <= 3'h7;
         wr(0, p[k], TGT_MODE, 8'h00);
      end
   endtask
   task automatic s_analog();
      logic [7:0] d;
      @(posedge clock);
      lv2 <= 8'hFF;
      wr(0, PORT_P2, TGT_PULLUP, 8'hF0);
      wr(0, PORT_P2, TGT_ANALOG, 8'h0F);
      tick(3);
      `CHK(analog_en, 4'hF)
      `CHK(p2_pullup, 8'hF0)
      rd(PORT_P2, TGT_LATCH, d);
      `CHK(d, 8'hF0)
      wr(0, PORT_P2, TGT_ANALOG, 8'h00);
      tick(3);
      rd(PORT_P2, TGT_LATCH, d);
      `CHK(d, 8'hFF)
   endtask
   // low nibble driven, bit 1 cleared by a bit write
   task automatic s_bitop();
      @(posedge clock);
      lv2 <= 8'h5A;
      wr(0, PORT_P2, TGT_LATCH, 8'hFF);
      wr(0, PORT_P2, TGT_MODE, 8'h0F);
      wr(1, PORT_P2, TGT_LATCH, 8'h01);
      tick(3);
      `CHK(p2_out, 8'h5D)
      `CHK(p2_oe, 8'h0F)
      wr(0, PORT_P2, TGT_ANALOG, 8'h03);
      tick(3);
      `CHK(p2_oe, 8'h0C)
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // main sequence
   initial begin
      s_hold();
      s_rst_pin();
      s_irq();
      s_analog();
      s_bitop();
      print_verdict();
   end
   // watchdog against a hang
   initial begin
      repeat (3000) @(posedge clock);
      errors++;
      print_verdict();
   end
endmodule // pcc_port_tb
bind pcc_port pcc_asserts u_chk (.clock, .reset_n, .p3_in, .rd_port,
   .rd_target, .irq_mask, .rd_data, .p2_pullup, .p3_out, .p3_oe, .p3_pullup,
   .p4_out, .p4_oe, .analog_en, .osc_pulldown, .core_reset_n,
   .reset_pin_is_port, .irq_flag, .irq_req);
